// ==== design/trigger_detect.sv ====
// module: pin synchroniser and qualified falling-edge trigger detector
`timescale 1ns/1ns
module trigger_detect
   import wdog_pkg::*;
#(
   parameter int unsigned MIN_CYC = MIN_PULSE_CYC
)
(
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      trigger
);
   // ==========================================================
   // three-stage synchroniser; stage 0 only feeds stage 1
   logic [2:0]         sync_reg;
   logic               level_reg;
   logic [PULSE_W-1:0] low_cnt_reg;
   logic               armed_reg;
   logic               trigger_reg;

   wire agree    = (sync_reg[1] == sync_reg[2]);
   wire level    = agree ? sync_reg[2] : level_reg;
   wire fall     = level_reg & ~level;
   wire long_low = (low_cnt_reg >= PULSE_W'(MIN_CYC - 1));
   // one strobe per qualified pulse, however long the pin stays low
   wire fire     = armed_reg & ~level & long_low;

   // stored level, low-time counter, armed on falling edge
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_reg    <= PIN_RESET;
         level_reg   <= 1'b1;
         low_cnt_reg <= '0;
         armed_reg   <= 1'b0;
         trigger_reg <= 1'b0;
      end
      else
      begin
         sync_reg    <= {sync_reg[1:0], pin};
         level_reg   <= level;
         trigger_reg <= fire;
         if (fall)
         begin
            armed_reg   <= 1'b1;
            low_cnt_reg <= '0;
         end
         else if (!level && !long_low)
            low_cnt_reg <= low_cnt_reg + 1'b1;
         if (level || fire)
            armed_reg <= 1'b0; // short glitches drop; a second strobe would fault
      end
   end

   assign trigger = trigger_reg;
endmodule

// ==== design/wdog_pkg.sv ====
// package: timing constants and state encodings for the window watchdog
package wdog_pkg;
   // ==========================================================
   // clock and fast-mode times
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned RESET_DELAY_MS  = 16;
   localparam int unsigned IGNORE_MS       = 32;
   localparam int unsigned CLOSED_MS       = 32;
   localparam int unsigned OPEN_MS         = 32;
   localparam int unsigned LONG_OPEN_MULT  = 4;
   localparam int unsigned LONG_OPEN_MS    = LONG_OPEN_MULT * OPEN_MS;
   localparam int unsigned MIN_PULSE_NS    = 1000;
   // ==========================================================
   // derived cycle counts (least time rounds up)
   localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
   localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_MS * CYC_PER_MS;
   localparam int unsigned IGNORE_CYC      = IGNORE_MS * CYC_PER_MS;
   localparam int unsigned CLOSED_CYC      = CLOSED_MS * CYC_PER_MS;
   localparam int unsigned OPEN_CYC        = OPEN_MS * CYC_PER_MS;
   localparam int unsigned LONG_OPEN_CYC   = LONG_OPEN_MS * CYC_PER_MS;
   localparam int unsigned MIN_PULSE_CYC   =
      (MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned CNT_W           = 24;
   localparam int unsigned PULSE_W         = 8;
   localparam logic [1:0]  SYNC_RESET      = 2'h0;
   localparam logic [2:0]  PIN_RESET       = 3'h7;
   // ==========================================================
   // mode pin encodings {mode_select_2, mode_select_1}
   localparam logic [1:0]  MODE_FAST       = 2'h0;
   localparam logic [1:0]  MODE_SLOW       = 2'h1;
   localparam logic [1:0]  MODE_OFF        = 2'h2;
   // ==========================================================
   typedef enum logic [4:0]
   {
      ST_DELAY  = 5'h01,
      ST_IGNORE = 5'h02,
      ST_LONG   = 5'h04,
      ST_CLOSED = 5'h08,
      ST_OPEN   = 5'h10
   } wd_state_e;
endpackage

// ==== design/window_watchdog_reset.sv ====
// module: window watchdog driving an active-low processor reset
// Contract
// - mode pins choose fast, slow or watchdog off
// - both mode pins low gives fast timing
// - after power-on hold reset low for the 16 ms delay
// - reset release starts a 32 ms ignore window
// - trigger input is disregarded during the ignore window
// - ignore end starts long open window of 128 ms
// - valid trigger in long open window starts 32 ms closed window
// - falling edge on trigger input is the trigger
// - trigger valid only if long enough and before open window ends
// - closed window end starts a 32 ms open window
// - valid trigger ends the standard open window at once
// - open window expiring without trigger asserts reset
// - trigger during closed window asserts reset
// - undervoltage indication forces reset low
`timescale 1ns/1ns
module window_watchdog_reset
   import wdog_pkg::*;
#(
   parameter int unsigned RESET_DELAY = RESET_DELAY_CYC,
   parameter int unsigned IGNORE      = IGNORE_CYC,
   parameter int unsigned CLOSED      = CLOSED_CYC,
   parameter int unsigned OPEN        = OPEN_CYC,
   parameter int unsigned LONG_OPEN   = LONG_OPEN_CYC,
   parameter int unsigned MIN_PULSE   = MIN_PULSE_CYC
)
(
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic watchdog_trigger_in,
   input  wire logic mode_select_1,
   input  wire logic mode_select_2,
   input  wire logic undervoltage,
   output logic      reset_out_n
);
   // ==========================================================
   // reset release synchroniser
   logic [1:0] rst_sync_reg;
   wire        rst_n = rst_sync_reg[1];

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         rst_sync_reg <= SYNC_RESET;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end

   // ==========================================================
   // mode pins pass three flops, a change counts once two agree
   logic [2:0] ms1_reg;
   logic [2:0] ms2_reg;
   logic [1:0] mode_reg;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ms1_reg  <= 3'h0;
         ms2_reg  <= 3'h0;
         mode_reg <= MODE_FAST;
      end
      else
      begin
         ms1_reg <= {ms1_reg[1:0], mode_select_1};
         ms2_reg <= {ms2_reg[1:0], mode_select_2};
         if (ms1_reg[1] == ms1_reg[2] && ms2_reg[1] == ms2_reg[2])
            mode_reg <= {ms2_reg[2], ms1_reg[2]};
      end
   end

   // undervoltage is asynchronous too: same three-flop treatment
   logic [2:0] uv_reg;
   logic       uv_level_reg;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         uv_reg       <= 3'h0;
         uv_level_reg <= 1'b0;
      end
      else
      begin
         uv_reg <= {uv_reg[1:0], undervoltage};
         if (uv_reg[1] == uv_reg[2])
            uv_level_reg <= uv_reg[2];
      end
   end

   // ==========================================================
   // trigger qualification
   logic trigger;

   trigger_detect #(
      .MIN_CYC (MIN_PULSE)
   ) trigger_detect_i (
      .clock   (clock),
      .rst_n   (rst_n),
      .pin     (watchdog_trigger_in),
      .trigger (trigger)
   );

   // ==========================================================
   // window sequencer
   wd_state_e          state_reg;
   wd_state_e          state_next;
   logic [CNT_W-1:0]   cnt_reg;
   logic [CNT_W-1:0]   cnt_next;
   logic               rst_out_reg;

   // slow mode doubles every length by shifting the terminal count
   wire       slow    = (mode_reg == MODE_SLOW);
   wire       wd_off  = (mode_reg == MODE_OFF);
   wire [4:0] sh      = slow ? 5'h1 : 5'h0;
   wire [CNT_W-1:0] t_delay  = CNT_W'(RESET_DELAY - 1) << sh | CNT_W'(slow);
   wire [CNT_W-1:0] t_ignore = CNT_W'(IGNORE - 1) << sh | CNT_W'(slow);
   wire [CNT_W-1:0] t_closed = CNT_W'(CLOSED - 1) << sh | CNT_W'(slow);
   wire [CNT_W-1:0] t_open   = CNT_W'(OPEN - 1) << sh | CNT_W'(slow);
   wire [CNT_W-1:0] t_long   = CNT_W'(LONG_OPEN - 1) << sh | CNT_W'(slow);

   wire done_delay  = (cnt_reg >= t_delay);
   wire done_ignore = (cnt_reg >= t_ignore);
   wire done_closed = (cnt_reg >= t_closed);
   wire done_open   = (cnt_reg >= t_open);
   wire done_long   = (cnt_reg >= t_long);

   // next state; fault returns to the reset delay
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg + 1'b1;
      case (state_reg)
         ST_DELAY:
            if (done_delay)
            begin
               state_next = ST_IGNORE;
               cnt_next   = '0;
            end
         ST_IGNORE:
            if (wd_off)
               cnt_next = '0; // off: stay released until undervoltage
            else if (done_ignore) // trigger ignored here
            begin
               state_next = ST_LONG;
               cnt_next   = '0;
            end
         ST_LONG:
            if (trigger)
            begin
               state_next = ST_CLOSED;
               cnt_next   = '0;
            end
            else if (done_long)
            begin
               state_next = ST_DELAY;
               cnt_next   = '0;
            end
         ST_CLOSED:
            if (trigger)
            begin
               state_next = ST_DELAY;
               cnt_next   = '0;
            end
            else if (done_closed)
            begin
               state_next = ST_OPEN;
               cnt_next   = '0;
            end
         ST_OPEN:
            if (trigger)
            begin
               state_next = ST_CLOSED;
               cnt_next   = '0;
            end
            else if (done_open)
            begin
               state_next = ST_DELAY;
               cnt_next   = '0;
            end
         default:
         begin
            state_next = ST_DELAY;
            cnt_next   = '0;
         end
      endcase
      // off mode never faults once past the delay
      if (wd_off && state_reg != ST_DELAY)
      begin
         state_next = ST_IGNORE;
         cnt_next   = '0;
      end
      // undervoltage restarts from the delay
      if (uv_level_reg)
      begin
         state_next = ST_DELAY;
         cnt_next   = '0;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg   <= ST_DELAY;
         cnt_reg     <= '0;
         rst_out_reg <= 1'b0;
      end
      else
      begin
         state_reg   <= state_next;
         cnt_reg     <= cnt_next;
         rst_out_reg <= (state_next != ST_DELAY);
      end
   end

   // registered, low through power-on delay
   assign reset_out_n = rst_out_reg;
endmodule

// ==== verif/cpu_model.sv ====
// partner: processor side that services the trigger pin
`timescale 1ns/1ns
module cpu_model
(
   input  wire logic clock,
   output logic      trigger_pin
);
   initial trigger_pin = 1'b1;
   // ==================================================
   // pulses held well past the qualify width
   task automatic service(input int cnt, input int gap);
      repeat (cnt)
      begin
         repeat (gap) @(posedge clock);
         trigger_pin <= 1'b0;
         repeat (8) @(posedge clock);
         trigger_pin <= 1'b1;
      end
   endtask
endmodule

// ==== verif/test_window_watchdog_reset.sv ====
// testbench: window watchdog against a processor model
`timescale 1ns/1ns
module test_window_watchdog_reset
   import wdog_pkg::*;
;
   // ==================================================
   // short counts keep the run small
   localparam int RD = 40;
   localparam int IG = 80;
   localparam int CL = 80;
   localparam int OP = 80;
   localparam int LO = 320;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic mode_select_1 = 1'b0;
   logic mode_select_2 = 1'b0;
   logic undervoltage = 1'b0;
   wire  trig;
   wire  reset_out_n;
   int   error_cnt = 0;
   int   cmp_count = 0;
   int   n;
   initial
   begin
      forever #20 clock = ~clock;
   end
   cpu_model cpu_model_i (.clock(clock), .trigger_pin(trig));
   window_watchdog_reset #(
      .RESET_DELAY(RD), .IGNORE(IG), .CLOSED(CL), .OPEN(OP),
      .LONG_OPEN(LO), .MIN_PULSE(4)
   ) window_watchdog_reset_i (
      .clock(clock), .rstn(rstn), .watchdog_trigger_in(trig),
      .mode_select_1(mode_select_1), .mode_select_2(mode_select_2),
      .undervoltage(undervoltage), .reset_out_n(reset_out_n)
   );
   // ==================================================
   // shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("errors %0d, checks %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // bounded wait, n counts the cycles it took
   task automatic wait_rst(input logic v, input int lim);
      n = 0;
      while (reset_out_n !== v)
      begin
         @(posedge clock);
         #1;
         n++;
         if (n > lim)
         begin
            error_cnt++;
            print_verdict();
         end
      end
   endtask
   task automatic do_reset(input logic [1:0] m);
      @(posedge clock);
      rstn <= 1'b0;
      {mode_select_2, mode_select_1} <= m;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      wait_rst(1'b1, 2 * RD + 16);
   endtask
   // ==================================================
   // scenarios
   task automatic t_fast();
      cpu_model_i.service(1, 20);
      cpu_model_i.service(1, 71);
      chk(reset_out_n, 1'b1);
      cpu_model_i.service(2, 100);
      chk(reset_out_n, 1'b1);
      cpu_model_i.service(1, 20);
      wait_rst(1'b0, 30);
      chk(reset_out_n, 1'b0);
      wait_rst(1'b1, RD + 16);
      chk(n >= RD, 1'b1);
   endtask
   task automatic t_miss();
      wait_rst(1'b0, IG + LO + 16);
      chk(n >= IG + LO, 1'b1);
      wait_rst(1'b1, RD + 16);
      cpu_model_i.service(1, 100);
      wait_rst(1'b0, CL + OP + 20);
      chk(n >= CL + OP - 10, 1'b1);
   endtask
   task automatic t_slow();
      do_reset(MODE_SLOW);
      chk(n >= 2 * RD, 1'b1);
      wait_rst(1'b0, 2 * (IG + LO) + 16);
      chk(n >= 2 * (IG + LO), 1'b1);
   endtask
   task automatic t_off();
      do_reset(MODE_OFF);
      cpu_model_i.service(4, 30);
      repeat (600) @(posedge clock);
      chk(reset_out_n, 1'b1);
      undervoltage <= 1'b1;
      wait_rst(1'b0, 8);
      repeat (20) @(posedge clock);
      chk(reset_out_n, 1'b0);
      undervoltage <= 1'b0;
      wait_rst(1'b1, RD + 16);
   endtask
   initial
   begin
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      wait_rst(1'b1, RD + 16);
      chk(n >= RD, 1'b1);
      t_fast();
      t_miss();
      t_slow();
      t_off();
      print_verdict();
   end
endmodule

// ==== verif/wdog_checker.sv ====
// checker: port-level assertions for the window watchdog
`timescale 1ns/1ns
module wdog_checker
   import wdog_pkg::*;
#(
   parameter int unsigned RESET_DELAY = 40,
   parameter int unsigned IGNORE      = 80,
   parameter int unsigned LONG_OPEN   = 320
)
(
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic watchdog_trigger_in,
   input  wire logic mode_select_1,
   input  wire logic mode_select_2,
   input  wire logic undervoltage,
   input  wire logic reset_out_n
);
   // ==================================================
   // helper counters; uv_reg covers the supply sync lag
   wire  [1:0]  mode = {mode_select_2, mode_select_1};
   wire         slow = (mode == MODE_SLOW);
   logic [3:0]  uv_reg;
   int unsigned low_reg, hi_reg, gap_reg, dly, lim;
   assign dly = slow ? 2 * RESET_DELAY : RESET_DELAY;
   assign lim = (slow ? 2 : 1) * (IGNORE + LONG_OPEN) + 16;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         uv_reg  <= 4'h0;
         low_reg <= 0;
         hi_reg  <= 0;
         gap_reg <= 0;
      end
      else
      begin
         uv_reg  <= undervoltage ? 4'hF : (|uv_reg ? uv_reg - 4'h1 : 4'h0);
         low_reg <= (reset_out_n || undervoltage) ? 0 : low_reg + 1;
         hi_reg  <= reset_out_n ? hi_reg + 1 : 0;
         gap_reg <= (!reset_out_n || $fell(watchdog_trigger_in)) ?
                    0 : gap_reg + 1;
      end
   end
   // ==================================================
   // assertions
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   property p_start;
      $rose(rstn) |-> !reset_out_n [*8];
   endproperty
   a_start: assert property (p_start)
      else $error("reset released early");
   property p_dmin;
      $rose(reset_out_n) |-> low_reg >= dly;
   endproperty
   a_dmin: assert property (p_dmin)
      else $error("delay too short");
   property p_dmax;
      !reset_out_n |-> low_reg <= dly + 16;
   endproperty
   a_dmax: assert property (p_dmax)
      else $error("delay too long");
   property p_ign;
      $fell(reset_out_n) |-> hi_reg >= IGNORE || |uv_reg;
   endproperty
   a_ign: assert property (p_ign)
      else $error("fault in ignore");
   property p_off;
      $fell(reset_out_n) && mode == MODE_OFF |-> |uv_reg;
   endproperty
   a_off: assert property (p_off)
      else $error("fault while off");
   property p_miss;
      reset_out_n && mode != MODE_OFF |-> gap_reg <= lim;
   endproperty
   a_miss: assert property (p_miss)
      else $error("missed trigger kept");
   property p_uvf;
      $rose(undervoltage) |-> ##[1:6] !reset_out_n;
   endproperty
   a_uvf: assert property (p_uvf)
      else $error("no supply reset");
   property p_uvh;
      undervoltage && $past(undervoltage, 6) |-> !reset_out_n;
   endproperty
   a_uvh: assert property (p_uvh)
      else $error("supply reset lost");
endmodule
bind window_watchdog_reset wdog_checker #(
   .RESET_DELAY(RESET_DELAY), .IGNORE(IGNORE), .LONG_OPEN(LONG_OPEN)
) wdog_checker_i (
   .clock(clock), .rstn(rstn), .watchdog_trigger_in(watchdog_trigger_in),
   .mode_select_1(mode_select_1), .mode_select_2(mode_select_2),
   .undervoltage(undervoltage), .reset_out_n(reset_out_n)
);
